//--- logic/duart_modem_pins_bus_select.sv
// Pin layer of a dual UART: irq gating, channel B modem pins, host bus style
`timescale 1ns/1ns
module duart_modem_pins_bus_select
    import duart_pins_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic [7:0] chan_a_modem_control_reg_in,
    input wire logic [7:0] chan_b_modem_control_reg_in,
    input wire logic chan_a_irq_req_in,
    input wire logic chan_b_irq_req_in,
    input wire logic chan_b_core_serial_in,
    input wire logic bus_style_sel_in,
    input wire host_pins_s host_pins_in,
    input wire logic chan_b_serial_in,
    input wire logic chan_b_clear_to_send_n_in,
    input wire logic chan_b_set_ready_n_in,
    input wire logic chan_b_carrier_detect_n_in,
    input wire logic chan_b_ring_indicator_n_in,
    input wire logic osc_clock_in,
    output logic osc_clock_out,
    output logic chan_a_irq_out,
    output logic chan_a_irq_oe_out,
    output logic chan_b_irq_out,
    output logic chan_b_irq_oe_out,
    output logic chan_a_irq_gate_out,
    output logic chan_b_irq_gate_out,
    output logic chan_a_request_to_send_n_out,
    output logic chan_b_request_to_send_n_out,
    output logic chan_b_terminal_ready_n_out,
    output logic chan_b_serial_out,
    output logic chan_b_rx_data_out,
    output logic chan_b_cts_active_out,
    output modem_status_s chan_b_modem_status_out,
    output host_access_s host_access_out
);

    // ------------------------------------------------------------
    // Next-value computation
    // ------------------------------------------------------------
    logic next_a_irq;
    logic next_a_oe;
    logic next_b_irq;
    logic next_b_oe;
    logic next_a_gate;
    logic next_b_gate;
    logic next_a_rts_n;
    logic next_b_rts_n;
    logic next_b_dtr_n;
    modem_status_s next_status;
    host_access_s next_access;
    bus_style_e style;
    // Low in reset and on the release edge, so checks skip the edge the flops still reset on
    logic regs_live;

    // Irq enable, modem outputs and status decode
    always_comb begin
        next_a_oe = chan_a_modem_control_reg_in[CTRL_IRQ_EN_BIT];
        next_a_irq = chan_a_irq_req_in & next_a_oe;
        next_a_gate = irq_gate_level(chan_a_modem_control_reg_in);
        next_b_oe = chan_b_modem_control_reg_in[CTRL_IRQ_EN_BIT];
        next_b_irq = chan_b_irq_req_in & next_b_oe;
        next_b_gate = irq_gate_level(chan_b_modem_control_reg_in);
        next_a_rts_n = ~chan_a_modem_control_reg_in[CTRL_RTS_BIT];
        next_b_rts_n = ~chan_b_modem_control_reg_in[CTRL_RTS_BIT];
        next_b_dtr_n = ~chan_b_modem_control_reg_in[CTRL_DTR_BIT];
        // Status only; never routed to the serial path
        next_status.clear_to_send = ~chan_b_clear_to_send_n_in;
        next_status.set_ready = ~chan_b_set_ready_n_in;
        next_status.carrier_detect = ~chan_b_carrier_detect_n_in;
        next_status.ring_indicator = ~chan_b_ring_indicator_n_in;
    end

    // Host strobe decode by bus style
    always_comb begin
        style = bus_style_sel_in ? BUS_SPLIT_STROBE : BUS_RW_LINE;
        next_access = '0;
        case (style)
            BUS_SPLIT_STROBE: begin
                next_access.rd = ~host_pins_in.chip_sel_n & ~host_pins_in.rd_strobe_n;
                next_access.wr = ~host_pins_in.chip_sel_n & ~host_pins_in.wr_strobe_n;
            end
            BUS_RW_LINE: begin
                next_access.rd = ~host_pins_in.chip_sel_n & host_pins_in.rw_line;
                next_access.wr = ~host_pins_in.chip_sel_n & ~host_pins_in.rw_line;
            end
            default: next_access = '0;
        endcase
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            chan_a_irq_out <= 1'b0;
            chan_a_irq_oe_out <= CTRL_RESET[CTRL_IRQ_EN_BIT];
            chan_b_irq_out <= 1'b0;
            chan_b_irq_oe_out <= CTRL_RESET[CTRL_IRQ_EN_BIT];
            chan_a_irq_gate_out <= PIN_INACTIVE;
            chan_b_irq_gate_out <= PIN_INACTIVE;
            chan_a_request_to_send_n_out <= PIN_INACTIVE;
            chan_b_request_to_send_n_out <= PIN_INACTIVE;
            chan_b_terminal_ready_n_out <= PIN_INACTIVE;
            chan_b_serial_out <= SERIAL_IDLE;
            chan_b_rx_data_out <= SERIAL_IDLE;
            chan_b_cts_active_out <= 1'b0;
            chan_b_modem_status_out <= STATUS_RESET;
            host_access_out <= '0;
            osc_clock_out <= 1'b0;
            regs_live <= 1'b0;
        end else begin
            chan_a_irq_out <= next_a_irq;
            chan_a_irq_oe_out <= next_a_oe;
            chan_b_irq_out <= next_b_irq;
            chan_b_irq_oe_out <= next_b_oe;
            chan_a_irq_gate_out <= next_a_gate;
            chan_b_irq_gate_out <= next_b_gate;
            chan_a_request_to_send_n_out <= next_a_rts_n;
            chan_b_request_to_send_n_out <= next_b_rts_n;
            chan_b_terminal_ready_n_out <= next_b_dtr_n;
            chan_b_serial_out <= chan_b_core_serial_in;
            chan_b_rx_data_out <= chan_b_serial_in;
            chan_b_cts_active_out <= next_status.clear_to_send;
            chan_b_modem_status_out <= next_status;
            host_access_out <= next_access;
            osc_clock_out <= osc_clock_in; // Buffered oscillator level
            regs_live <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // All checks wait for regs_live: on the release edge the flops still take reset values
    property p_a_enable;
        @(posedge clk_sys_in) disable iff (!arst_n_in || !regs_live)
        chan_a_modem_control_reg_in[CTRL_IRQ_EN_BIT]
            |=> chan_a_irq_oe_out && !chan_a_irq_gate_out;
    endproperty
    a_a_enable: assert property (p_a_enable) else $error("chan a irq not enabled");

    property p_a_irq_value;
        @(posedge clk_sys_in) disable iff (!arst_n_in || !regs_live)
        chan_a_modem_control_reg_in[CTRL_IRQ_EN_BIT]
            |=> chan_a_irq_out == $past(chan_a_irq_req_in);
    endproperty
    a_a_irq_value: assert property (p_a_irq_value) else $error("chan a irq value lost");

    property p_a_disable;
        @(posedge clk_sys_in) disable iff (!arst_n_in || !regs_live)
        !chan_a_modem_control_reg_in[CTRL_IRQ_EN_BIT]
            |=> !chan_a_irq_oe_out && chan_a_irq_gate_out;
    endproperty
    a_a_disable: assert property (p_a_disable) else $error("chan a irq not disabled");

    property p_b_enable;
        @(posedge clk_sys_in) disable iff (!arst_n_in || !regs_live)
        chan_b_modem_control_reg_in[CTRL_IRQ_EN_BIT]
            |=> chan_b_irq_oe_out && !chan_b_irq_gate_out;
    endproperty
    a_b_enable: assert property (p_b_enable) else $error("chan b irq not enabled");

    property p_b_irq_value;
        @(posedge clk_sys_in) disable iff (!arst_n_in || !regs_live)
        chan_b_modem_control_reg_in[CTRL_IRQ_EN_BIT]
            |=> chan_b_irq_out == $past(chan_b_irq_req_in);
    endproperty
    a_b_irq_value: assert property (p_b_irq_value) else $error("chan b irq value lost");

    property p_b_disable;
        @(posedge clk_sys_in) disable iff (!arst_n_in || !regs_live)
        !chan_b_modem_control_reg_in[CTRL_IRQ_EN_BIT]
            |=> !chan_b_irq_oe_out && chan_b_irq_gate_out;
    endproperty
    a_b_disable: assert property (p_b_disable) else $error("chan b irq not disabled");

    sequence s_split_read;
        bus_style_sel_in && !host_pins_in.chip_sel_n && !host_pins_in.rd_strobe_n;
    endsequence
    property p_split;
        @(posedge clk_sys_in) disable iff (!arst_n_in || !regs_live)
        s_split_read |=> host_access_out.rd;
    endproperty
    a_split: assert property (p_split) else $error("split strobe read missed");

    sequence s_rw_write;
        !bus_style_sel_in && !host_pins_in.chip_sel_n && !host_pins_in.rw_line;
    endsequence
    property p_rwline;
        @(posedge clk_sys_in) disable iff (!arst_n_in || !regs_live)
        s_rw_write |=> host_access_out.wr && !host_access_out.rd;
    endproperty
    a_rwline: assert property (p_rwline) else $error("rw line write missed");

    property p_status_only;
        @(posedge clk_sys_in) disable iff (!arst_n_in || !regs_live)
        1'b1 |=> chan_b_rx_data_out == $past(chan_b_serial_in)
            && chan_b_serial_out == $past(chan_b_core_serial_in);
    endproperty
    a_status_only: assert property (p_status_only) else $error("serial path altered");

    property p_b_rts;
        @(posedge clk_sys_in) disable iff (!arst_n_in || !regs_live)
        1'b1 |=> chan_b_request_to_send_n_out
            == !$past(chan_b_modem_control_reg_in[CTRL_RTS_BIT]);
    endproperty
    a_b_rts: assert property (p_b_rts) else $error("chan b rts polarity");

    property p_b_cts;
        @(posedge clk_sys_in) disable iff (!arst_n_in || !regs_live)
        !chan_b_clear_to_send_n_in |=> chan_b_cts_active_out;
    endproperty
    a_b_cts: assert property (p_b_cts) else $error("chan b cts polarity");

    property p_b_dtr;
        @(posedge clk_sys_in) disable iff (!arst_n_in || !regs_live)
        chan_b_modem_control_reg_in[CTRL_DTR_BIT] |=> !chan_b_terminal_ready_n_out;
    endproperty
    a_b_dtr: assert property (p_b_dtr) else $error("chan b dtr polarity");

    property p_a_rts;
        @(posedge clk_sys_in) disable iff (!arst_n_in || !regs_live)
        chan_a_modem_control_reg_in[CTRL_RTS_BIT] |=> !chan_a_request_to_send_n_out;
    endproperty
    a_a_rts: assert property (p_a_rts) else $error("chan a rts polarity");

endmodule : duart_modem_pins_bus_select

//--- logic/duart_pins_pkg.sv
// Shared constants and carrier types for the dual UART pin block
package duart_pins_pkg;

    // ------------------------------------------------------------
    // Modem control register layout
    // ------------------------------------------------------------
    localparam int CTRL_WIDTH = 8;
    localparam int CTRL_DTR_BIT = 0;
    localparam int CTRL_RTS_BIT = 1;
    localparam int CTRL_IRQ_EN_BIT = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ------------------------------------------------------------
    // Host bus styles
    // ------------------------------------------------------------
    typedef enum logic {BUS_RW_LINE, BUS_SPLIT_STROBE} bus_style_e;

    // Host strobe carrier from the raw host pins
    typedef struct packed {
        logic chip_sel_n;
        logic rd_strobe_n;
        logic wr_strobe_n;
        logic rw_line;
    } host_pins_s;

    // Decoded host access
    typedef struct packed {
        logic rd;
        logic wr;
    } host_access_s;

    // Channel B modem input status
    typedef struct packed {
        logic clear_to_send;
        logic set_ready;
        logic carrier_detect;
        logic ring_indicator;
    } modem_status_s;

    // ------------------------------------------------------------
    // Reset levels of the pins
    // ------------------------------------------------------------
    localparam logic SERIAL_IDLE = 1'b1;
    localparam logic PIN_INACTIVE = 1'b1;
    localparam logic [3:0] STATUS_RESET = 4'h0;

    // Irq gate pin level for a given control bit
    function automatic logic irq_gate_level(input logic [7:0] ctrl);
        return ~ctrl[CTRL_IRQ_EN_BIT];
    endfunction : irq_gate_level

endpackage : duart_pins_pkg

//--- dv/modem_peer.sv
// Channel B serial and modem peer model
`timescale 1ns/1ns
module modem_peer (
    input wire logic clk_in,
    input wire logic send_in,
    input wire logic [7:0] byte_in,
    input wire logic [3:0] status_n_in,
    output logic line_out,
    output logic [3:0] status_n_out
);
    logic [9:0] shift = 10'h3ff;
    // Start bit, data low bit first, stop; the line refills with ones so it idles high
    always @(posedge clk_in) begin
        if (send_in) begin
            shift <= {1'h1, byte_in, 1'h0};
        end else begin
            shift <= {1'h1, shift[9:1]};
        end
    end
    assign line_out = shift[0];
    // Status levels {cts, dsr, cd, ri} straight to the pins
    assign status_n_out = status_n_in;
endmodule : modem_peer

//--- dv/duart_modem_pins_bus_select_test.sv
// Self-checking bench for the dual UART pin block
`timescale 1ns/1ns
module duart_modem_pins_bus_select_test;
    import duart_pins_pkg::*;
    // ------------------------------------------------------------
    // Stimulus, table and checking
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ma;
        logic [7:0] mb;
        logic st;
        host_pins_s hp;
        logic [1:0] acc;
        logic [3:0] gates;
    } row_s;
    localparam int ROWS = 6;
    // Gates field is {gate_a, oe_a, gate_b, oe_b}; acc is {rd, wr}
    localparam row_s TABLE [ROWS] = '{{8'h08, 8'h00, 1'h1, 4'h3, 2'h2, 4'h6},
        {8'h00, 8'h08, 1'h1, 4'h5, 2'h1, 4'h9}, {8'h0b, 8'h0f, 1'h0, 4'h1, 2'h2, 4'h5},
        {8'h00, 8'h00, 1'h0, 4'h6, 2'h1, 4'ha}, {8'hff, 8'hf7, 1'h0, 4'h8, 2'h0, 4'h6},
        {8'h0a, 8'h01, 1'h1, 4'h9, 2'h0, 4'h6}};
    logic clk_sys_in = 1'h0;
    logic arst_n = 1'h0;
    logic [7:0] ma = 8'h00;
    logic [7:0] mb = 8'h00;
    logic irq_a = 1'h0;
    logic irq_b = 1'h0;
    logic core_ser = 1'h1;
    logic style = 1'h1;
    host_pins_s hp = 4'he;
    logic osc = 1'h0;
    logic send = 1'h0;
    logic [3:0] st_n = 4'hf;
    logic rx_line;
    logic [3:0] pin_n;
    logic ga, gb, oa, ob, ia, ib, rts_a, rts_b, dtr_b, osc_o, ser_o, rx_o, cts_o;
    modem_status_s stat;
    host_access_s acc;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [11:0] frame;
    always #5 clk_sys_in = ~clk_sys_in;
    duart_modem_pins_bus_select duart_modem_pins_bus_select_inst (
        .clk_sys_in(clk_sys_in), .arst_n_in(arst_n), .chan_a_modem_control_reg_in(ma),
        .chan_b_modem_control_reg_in(mb), .chan_a_irq_req_in(irq_a), .chan_b_irq_req_in(irq_b),
        .chan_b_core_serial_in(core_ser), .bus_style_sel_in(style), .host_pins_in(hp),
        .chan_b_serial_in(rx_line), .chan_b_clear_to_send_n_in(pin_n[3]),
        .chan_b_set_ready_n_in(pin_n[2]), .chan_b_carrier_detect_n_in(pin_n[1]),
        .chan_b_ring_indicator_n_in(pin_n[0]), .osc_clock_in(osc), .osc_clock_out(osc_o),
        .chan_a_irq_out(ia), .chan_a_irq_oe_out(oa), .chan_b_irq_out(ib), .chan_b_irq_oe_out(ob),
        .chan_a_irq_gate_out(ga), .chan_b_irq_gate_out(gb),
        .chan_a_request_to_send_n_out(rts_a),
        .chan_b_request_to_send_n_out(rts_b), .chan_b_terminal_ready_n_out(dtr_b),
        .chan_b_serial_out(ser_o), .chan_b_rx_data_out(rx_o), .chan_b_cts_active_out(cts_o),
        .chan_b_modem_status_out(stat), .host_access_out(acc));
    modem_peer modem_peer_inst (.clk_in(clk_sys_in), .send_in(send), .byte_in(8'h4b),
        .status_n_in(st_n), .line_out(rx_line), .status_n_out(pin_n));
    task automatic chk_vec(input logic [3:0] got, input logic [3:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %b expected %b", $time, got, exp);
        end
    endtask : chk_vec
    task automatic end_of_test;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    // Hang guard, the whole run takes well under a hundred cycles
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk_vec({ga, oa, gb, ob}, 4'ha);
        @(posedge clk_sys_in);
        arst_n <= 1'h1;
        // Table rows: irq gating, host bus style decode, modem outputs
        for (int i = 0; i < ROWS; i++) begin
            @(posedge clk_sys_in);
            {ma, mb, style, hp} <= {TABLE[i].ma, TABLE[i].mb, TABLE[i].st, TABLE[i].hp};
            {irq_a, irq_b, osc, core_ser} <= {i[0], ~i[0], i[0], i[0]};
            @(posedge clk_sys_in);
            @(negedge clk_sys_in);
            chk_vec({ga, oa, gb, ob}, TABLE[i].gates);
            chk_vec({2'h0, acc}, {2'h0, TABLE[i].acc});
            chk_vec({rts_a, rts_b, dtr_b, osc_o}, {~ma[1], ~mb[1], ~mb[0], i[0]});
            chk_vec({ia, ib, ser_o, 1'h0}, {i[0] & ma[3], ~i[0] & mb[3], i[0], 1'h0});
        end
        // Each modem input alone; none may reach the transmit line
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys_in);
            st_n <= ~(4'h1 << k);
            @(posedge clk_sys_in);
            @(negedge clk_sys_in);
            chk_vec(stat, 4'h1 << k);
            chk_vec({cts_o, ser_o, 2'h0}, {k == 3, core_ser, 2'h0});
        end
        // Receive frame while the status pins keep changing
        frame = {3'h7, 8'h4b, 1'h0};
        @(posedge clk_sys_in);
        send <= 1'h1;
        @(posedge clk_sys_in);
        send <= 1'h0;
        for (int b = 0; b < 12; b++) begin
            @(posedge clk_sys_in);
            st_n <= st_n ^ 4'hf;
            @(negedge clk_sys_in);
            chk_vec({3'h0, rx_o}, {3'h0, frame[b]});
        end
        // Reset in mid-run, then reload on the first edge after release
        @(posedge clk_sys_in);
        {arst_n, ma, mb} <= {1'h0, 8'h08, 8'h08};
        @(negedge clk_sys_in);
        chk_vec({ga, oa, gb, ob}, 4'ha);
        @(posedge clk_sys_in);
        arst_n <= 1'h1;
        @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk_vec({ga, oa, gb, ob}, 4'h5);
        end_of_test();
    end
endmodule : duart_modem_pins_bus_select_test
